// ===== src/auto_fault_acknowledge.sv
`timescale 1ns/1ps
`include "afa_regs.svh"

// Summary of operation
// - Only the two overcurrent faults and overvoltage recover without user action.
// - A fault turns the power switches off, then waits the 0..1000 ms delay.
// - After the delay a quick speed search catches the machine, always quick mode.
// - At most 0..20 acknowledgements (default 5) are allowed in ten minutes.
// - A fault beyond the allowed count locks the switches off in fault state.
// - Each fault type has its own counter and is checked only against it.
module auto_fault_acknowledge
  import afa_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `AFA_CLK_HZ / `AFA_MS_PER_S,
  parameter int unsigned WINDOW_MS = `AFA_WINDOW_MIN * `AFA_MS_PER_MIN
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic overcurrent_fault_first,
  input wire logic overcurrent_fault_second,
  input wire logic overvoltage_fault,
  input wire logic [9:0] set_restart_delay_ms,
  input wire logic [4:0] set_ack_limit,
  input wire logic set_load,
  input wire logic search_done,
  input wire logic user_ack,
  output logic switches_off_q,
  output logic search_start_q,
  output logic quick_sync_q,
  output logic locked_q,
  output logic recovered_q,
  output logic [1:0] fault_type_q
);

  localparam int NF = `AFA_FAULT_TYPES;
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  seq_state_t state_q;
  seq_state_t state_d;
  logic [9:0] delay_set_q;
  logic [4:0] limit_q;
  logic [15:0] presc_q;
  logic tick_q;
  logic [9:0] delay_q;
  logic [NF-1:0] ack_q;
  logic [4:0] count_w [NF];
  logic [NF-1:0] fault_w;
  logic fault_any;
  fault_type_t sel_type;
  logic allowed;
  logic [4:0] pending;
  logic delay_over;

  // -----------------------------------------------------------------------
  // Settings
  // -----------------------------------------------------------------------
  // Settings are clamped to their range and taken on a load strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      delay_set_q <= `AFA_RESTART_DEF_MS;
      limit_q <= `AFA_ACK_LIMIT_DEF;
    end else if (set_load) begin
      if (set_restart_delay_ms > `AFA_RESTART_MAX_MS) begin
        delay_set_q <= `AFA_RESTART_MAX_MS;
      end else begin
        delay_set_q <= set_restart_delay_ms;
      end
      if (set_ack_limit > `AFA_ACK_LIMIT_MAX) begin
        limit_q <= `AFA_ACK_LIMIT_MAX;
      end else begin
        limit_q <= set_ack_limit;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Millisecond tick
  // -----------------------------------------------------------------------
  // Free-running prescaler shared by the delay and the counters
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      presc_q <= '0;
      tick_q <= 1'b0;
    end else if (presc_q == MS_LAST) begin
      presc_q <= '0;
      tick_q <= 1'b1;
    end else begin
      presc_q <= presc_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // -----------------------------------------------------------------------
  // Acknowledgement counters
  // -----------------------------------------------------------------------
  ack_if ack_bus [NF] ();

  generate
    for (genvar g = 0; g < NF; g++) begin : g_cnt
      assign ack_bus[g].tick_ms = tick_q;
      assign ack_bus[g].ack = ack_q[g];
      assign count_w[g] = ack_bus[g].count;

      ack_window_counter #(
        .WINDOW_MS(WINDOW_MS)
      ) u_cnt (
        .clk(clk),
        .sys_rst(sys_rst),
        .port(ack_bus[g])
      );
    end
  endgenerate

  // -----------------------------------------------------------------------
  // Fault decision
  // -----------------------------------------------------------------------
  // Only the three eligible faults enter; first overcurrent has priority
  assign fault_w = {overvoltage_fault, overcurrent_fault_second,
                    overcurrent_fault_first};
  assign fault_any = |fault_w;

  always_comb begin
    if (fault_w[0]) begin
      sel_type = FT_OVERCURRENT_FIRST;
    end else if (fault_w[1]) begin
      sel_type = FT_OVERCURRENT_SECOND;
    end else begin
      sel_type = FT_OVERVOLTAGE;
    end
  end

  // Recovery allowed only while this type's own count is below the limit.
  // An acknowledgement still on its way into the counter counts already,
  // so a fault held over several cycles cannot slip past the limit.
  assign pending = count_w[sel_type] + 5'(ack_q[sel_type]);
  assign allowed = pending < limit_q;
  assign delay_over = (delay_q == 10'h000);

  // -----------------------------------------------------------------------
  // Sequencer
  // -----------------------------------------------------------------------
  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN, ST_DELAY, ST_SEARCH: begin
        if (fault_any) begin
          if (allowed) begin
            state_d = ST_DELAY;
          end else begin
            state_d = ST_LOCKED;
          end
        end else if (state_q == ST_DELAY && delay_over) begin
          state_d = ST_SEARCH;
        end else if (state_q == ST_SEARCH && search_done) begin
          state_d = ST_RUN;
        end
      end
      ST_LOCKED: begin
        if (user_ack && !fault_any) begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_LOCKED;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Restart delay countdown, reloaded on each accepted fault
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      delay_q <= '0;
    end else if (state_d == ST_DELAY && state_q != ST_DELAY) begin
      delay_q <= delay_set_q;
    end else if (state_q == ST_DELAY && fault_any) begin
      delay_q <= delay_set_q;
    end else if (state_q == ST_DELAY && tick_q && !delay_over) begin
      delay_q <= delay_q - 10'h001;
    end
  end

  // One acknowledgement recorded on its own counter for each cycle that an accepted fault is present
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= '0;
    end else begin
      ack_q <= '0;
      if (state_q != ST_LOCKED && fault_any && allowed) begin
        ack_q[sel_type] <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  // Power switches stay off in every state but normal running
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      switches_off_q <= 1'b0;
    end else begin
      switches_off_q <= (state_d != ST_RUN);
    end
  end

  // Search request pulse and quick mode select while searching
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      search_start_q <= 1'b0;
      quick_sync_q <= 1'b0;
    end else begin
      search_start_q <= (state_d == ST_SEARCH) && (state_q != ST_SEARCH);
      quick_sync_q <= (state_d == ST_SEARCH);
    end
  end

  // Lockout flag, recovery pulse and last fault type
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      locked_q <= 1'b0;
      recovered_q <= 1'b0;
      fault_type_q <= FT_OVERCURRENT_FIRST;
    end else begin
      locked_q <= (state_d == ST_LOCKED);
      recovered_q <= (state_q == ST_SEARCH) && (state_d == ST_RUN);
      if (state_q != ST_LOCKED && fault_any) begin
        fault_type_q <= sel_type;
      end
    end
  end

endmodule

// ===== src/afa_regs.svh
`ifndef AFA_REGS_SVH
`define AFA_REGS_SVH

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
// Control clock rate in Hz
`define AFA_CLK_HZ 50000000
// Milliseconds in one second, used to derive the millisecond tick
`define AFA_MS_PER_S 1000
// Length of the acknowledgement window in minutes
`define AFA_WINDOW_MIN 10
// Milliseconds in one minute
`define AFA_MS_PER_MIN 60000

// ---------------------------------------------------------------------------
// Setting limits and reset values
// ---------------------------------------------------------------------------
// Restart delay in ms: upper bound and reset value
`define AFA_RESTART_MAX_MS 10'h3e8
`define AFA_RESTART_DEF_MS 10'h014
// Allowed acknowledgements per window: upper bound and reset value
`define AFA_ACK_LIMIT_MAX 5'h14
`define AFA_ACK_LIMIT_DEF 5'h05
// Timestamp slots per counter, enough for the largest limit
`define AFA_ACK_SLOTS 20
// Width of a slot age in ms
`define AFA_AGE_W 20
// Number of fault types that recover automatically
`define AFA_FAULT_TYPES 3

`endif

// ===== src/afa_pkg.sv
package afa_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_DELAY  = 4'b0010,
    ST_SEARCH = 4'b0100,
    ST_LOCKED = 4'b1000
  } seq_state_t;

  // Fault types, also the index of each acknowledgement counter
  typedef enum logic [1:0] {
    FT_OVERCURRENT_FIRST  = 2'h0,
    FT_OVERCURRENT_SECOND = 2'h1,
    FT_OVERVOLTAGE        = 2'h2
  } fault_type_t;

endpackage

// ===== src/ack_if.sv
`timescale 1ns/1ps

// Link between the sequencer and one acknowledgement counter
interface ack_if;
  logic tick_ms;
  logic ack;
  logic [4:0] count;

  modport main (output tick_ms, output ack, input count);
  modport counter (input tick_ms, input ack, output count);
endinterface

// ===== src/ack_window_counter.sv
`timescale 1ns/1ps
`include "afa_regs.svh"

// Counts the acknowledgements of one fault type over the last window
module ack_window_counter
  import afa_pkg::*;
#(
  parameter int unsigned WINDOW_MS = 600000
) (
  input wire logic clk,
  input wire logic sys_rst,
  ack_if.counter port
);

  localparam int SLOTS = `AFA_ACK_SLOTS;
  localparam logic [`AFA_AGE_W-1:0] AGE_LAST = `AFA_AGE_W'(WINDOW_MS - 1);

  logic [SLOTS-1:0] used_q;
  logic [`AFA_AGE_W-1:0] age_q [SLOTS];
  logic [SLOTS-1:0] ins_sel;
  logic [4:0] cnt;

  // ---------------------------------------------------------------------
  // Free slot search and occupancy count
  // ---------------------------------------------------------------------
  // Lowest free slot takes the next acknowledgement
  always_comb begin
    logic found;
    found = 1'b0;
    ins_sel = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (!used_q[i] && !found) begin
        ins_sel[i] = 1'b1;
        found = 1'b1;
      end
    end
  end

  // Live acknowledgements in the window
  always_comb begin
    cnt = '0;
    for (int i = 0; i < SLOTS; i++) begin
      cnt = cnt + 5'(used_q[i]);
    end
  end

  assign port.count = cnt;

  // ---------------------------------------------------------------------
  // Slot timestamps
  // ---------------------------------------------------------------------
  // Each slot ages by ms and frees itself when the window has passed
  always_ff @(posedge clk) begin
    for (int i = 0; i < SLOTS; i++) begin
      if (sys_rst) begin
        used_q[i] <= 1'b0;
        age_q[i] <= '0;
      end else if (port.ack && ins_sel[i]) begin
        used_q[i] <= 1'b1;
        age_q[i] <= '0;
      end else if (port.tick_ms && used_q[i]) begin
        if (age_q[i] == AGE_LAST) begin
          used_q[i] <= 1'b0;
        end
        age_q[i] <= age_q[i] + `AFA_AGE_W'(1);
      end
    end
  end

endmodule

// ===== tb/afa_monitor.sv
`timescale 1ns/1ps
// Watches the fault sequencer at its top-level ports
module afa_monitor (
  input logic clk,
  input logic sys_rst,
  input logic overcurrent_fault_first,
  input logic overcurrent_fault_second,
  input logic overvoltage_fault,
  input logic search_done,
  input logic user_ack,
  input logic switches_off_q,
  input logic search_start_q,
  input logic quick_sync_q,
  input logic locked_q,
  input logic recovered_q,
  input logic [1:0] fault_type_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic any_fault;
  logic oc2_only;
  logic ov_only;
  // Fault decode in priority order
  assign any_fault = overcurrent_fault_first | overcurrent_fault_second |
                     overvoltage_fault;
  assign oc2_only = !overcurrent_fault_first && overcurrent_fault_second;
  assign ov_only = any_fault && !overcurrent_fault_first &&
                   !overcurrent_fault_second;
  // ----
  // Assertions
  // ----
  fault_off_a: assert property (any_fault |=> switches_off_q)
    else $error("switches not off after fault");
  type_first_a: assert property (
    overcurrent_fault_first && !locked_q |=> fault_type_q == 2'h0)
    else $error("first overcurrent type wrong");
  type_second_a: assert property (
    oc2_only && !locked_q |=> fault_type_q == 2'h1)
    else $error("second overcurrent type wrong");
  type_volt_a: assert property (
    ov_only && !locked_q |=> fault_type_q == 2'h2)
    else $error("overvoltage type wrong");
  quick_search_a: assert property (
    search_start_q |-> quick_sync_q ##1 !search_start_q)
    else $error("search start not a quick pulse");
  recover_done_a: assert property (
    recovered_q |-> $past(search_done) && !switches_off_q && !quick_sync_q)
    else $error("recovery without finished search");
  locked_off_a: assert property (
    locked_q |-> switches_off_q && !search_start_q && !quick_sync_q)
    else $error("lockout not holding switches off");
  lock_hold_a: assert property (locked_q && !user_ack |=> locked_q)
    else $error("lockout left without user");
  lock_release_a: assert property (
    locked_q && user_ack && !any_fault |=> !locked_q && !switches_off_q)
    else $error("lockout not released");
  // Main scenarios
  cover property (recovered_q);
  cover property ($rose(locked_q));
  cover property (overvoltage_fault && !locked_q);
endmodule

// ===== tb/power_stage_model.sv
`timescale 1ns/1ps
// Power stage and spinning machine: reports the catch after a lag
module power_stage_model (
  input logic clk,
  input logic sys_rst,
  input logic search_start,
  input logic [3:0] lag,
  output logic done_q
);
  logic [3:0] left_q;
  logic busy_q;
  // Count the lag once a search starts, then flag the catch for one cycle
  always_ff @(posedge clk) begin
    done_q <= 1'b0;
    if (sys_rst) begin
      busy_q <= 1'b0;
      left_q <= 4'h0;
    end else if (search_start) begin
      busy_q <= 1'b1;
      left_q <= lag;
    end else if (busy_q && left_q == 4'h0) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end else if (busy_q) begin
      left_q <= left_q - 4'h1;
    end
  end
endmodule

// ===== tb/test_auto_fault_acknowledge.sv
`timescale 1ns/1ps
module test_auto_fault_acknowledge;
  import afa_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic overcurrent_fault_first = 1'b0;
  logic overcurrent_fault_second = 1'b0;
  logic overvoltage_fault = 1'b0;
  logic [9:0] set_restart_delay_ms = 10'h000;
  logic [4:0] set_ack_limit = 5'h00;
  logic set_load = 1'b0;
  logic user_ack = 1'b0;
  logic [3:0] lag = 4'h0;
  logic search_done, switches_off_q, search_start_q, quick_sync_q;
  logic locked_q, recovered_q;
  logic [1:0] fault_type_q;
  int bad_count = 0;
  int tests_run = 0;
  typedef struct {logic [2:0] f; logic [1:0] t; logic [3:0] lag;} row_t;
  row_t rows [5] = '{'{3'h1, 2'h0, 4'h0}, '{3'h2, 2'h1, 4'h5},
    '{3'h4, 2'h2, 4'h0}, '{3'h3, 2'h0, 4'h3}, '{3'h6, 2'h1, 4'h0}};

  // Clock
  always #10 clk = ~clk;

  auto_fault_acknowledge #(.MS_CYCLES(4), .WINDOW_MS(10)) DUT (.clk,
    .sys_rst, .overcurrent_fault_first, .overcurrent_fault_second,
    .overvoltage_fault, .set_restart_delay_ms, .set_ack_limit, .set_load,
    .search_done, .user_ack, .switches_off_q, .search_start_q,
    .quick_sync_q, .locked_q, .recovered_q, .fault_type_q);
  power_stage_model partner (.clk, .sys_rst, .search_start(search_start_q),
    .lag, .done_q(search_done));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [9:0] got, exp, input string nm);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Bounded wait for a flag, counting cycles
  task automatic wait_hi(ref logic sig, input int lim, output int n);
    n = 0;
    while (sig !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        chk(0, 1, "wait");
        end_of_test();
      end
    end
  endtask

  task automatic load(input logic [9:0] d, input logic [4:0] l);
    @(posedge clk);
    set_restart_delay_ms <= d;
    set_ack_limit <= l;
    set_load <= 1'b1;
    @(posedge clk);
    set_load <= 1'b0;
  endtask

  // One-cycle fault, then follow the recovery or the lockout
  task automatic hit(input logic [2:0] f, input logic [1:0] t,
                     input logic lk, input int lo, hi, input logic [3:0] g);
    int n;
    @(posedge clk);
    {overvoltage_fault, overcurrent_fault_second,
     overcurrent_fault_first} <= f;
    lag <= g;
    @(posedge clk);
    {overvoltage_fault, overcurrent_fault_second,
     overcurrent_fault_first} <= 3'h0;
    #1;
    chk(switches_off_q, 1, "off");
    chk(locked_q, lk, "locked");
    if (!lk) begin
      chk(fault_type_q, t, "type");
      wait_hi(search_start_q, hi + 4, n);
      chk(n >= lo && n <= hi, 1, "delay");
      chk(quick_sync_q, 1, "quick");
      wait_hi(recovered_q, 40, n);
      chk(switches_off_q, 0, "on");
    end
  endtask

  task automatic release_lock();
    @(posedge clk);
    user_ack <= 1'b1;
    @(posedge clk);
    user_ack <= 1'b0;
    #1;
    chk({locked_q, switches_off_q}, 0, "release");
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (20) @(posedge clk);
    #1;
    chk({switches_off_q, search_start_q, quick_sync_q, locked_q,
         recovered_q, fault_type_q}, 0, "reset");
    @(posedge clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
      hit(rows[i].f, rows[i].t, 0, 76, 86, rows[i].lag);
    load(10'h000, 5'h02);
    hit(3'h1, 2'h0, 0, 1, 2, 4'h0);
    hit(3'h1, 2'h0, 0, 1, 2, 4'h0);
    hit(3'h2, 2'h1, 0, 1, 2, 4'h0);
    hit(3'h1, 2'h0, 1, 0, 0, 4'h0);
    release_lock();
    repeat (60) @(posedge clk);
    hit(3'h1, 2'h0, 0, 1, 2, 4'h0);
    load(10'h000, 5'h00);
    hit(3'h4, 2'h2, 1, 0, 0, 4'h0);
    release_lock();
    load(10'h3ff, 5'h1f);
    hit(3'h4, 2'h2, 0, 3990, 4010, 4'h2);
    // Reset in the middle of a restart delay brings back the defaults
    @(posedge clk);
    overvoltage_fault <= 1'b1;
    @(posedge clk);
    overvoltage_fault <= 1'b0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({switches_off_q, quick_sync_q, locked_q}, 0, "reset again");
    @(posedge clk);
    sys_rst <= 1'b0;
    hit(3'h4, 2'h2, 0, 76, 86, 4'h1);
    // A fault held three cycles counts twice and locks on the third cycle at limit two
    load(10'h000, 5'h02);
    @(posedge clk);
    overcurrent_fault_second <= 1'b1;
    repeat (3) @(posedge clk);
    overcurrent_fault_second <= 1'b0;
    #1;
    chk(locked_q, 1, "held fault");
    release_lock();
    end_of_test();
  end
endmodule

bind auto_fault_acknowledge afa_monitor mon (.clk, .sys_rst,
  .overcurrent_fault_first, .overcurrent_fault_second, .overvoltage_fault,
  .search_done, .user_ack, .switches_off_q, .search_start_q, .quick_sync_q,
  .locked_q, .recovered_q, .fault_type_q);
